/* File: verilog/lds_defs.vh */
`ifndef LDS_DEFS_VH
`define LDS_DEFS_VH

// Register byte addresses
`define LDS_ADDR_CTRL0 8'h80
`define LDS_ADDR_T1ROW 8'h81
`define LDS_ADDR_T2ROW 8'h82
`define LDS_ADDR_C1DIR 8'h83
`define LDS_ADDR_C2DIR 8'h84
`define LDS_ADDR_SRCSEL 8'h85
`define LDS_ADDR_WECTL 8'h86
`define LDS_ADDR_ADCST 8'h87
`define LDS_ADDR_RSV_LO 8'h88
`define LDS_ADDR_RSV_HI 8'h8F
`define LDS_T1_BASE 8'h90
`define LDS_T2_BASE 8'hD0

// Control register 0 fields
`define LDS_C0_OUT2DIR 7
`define LDS_C0_OUT1DIR 6
`define LDS_C0_VOLSEL 5
`define LDS_C0_FILTDIS 4
`define LDS_C0_REFMODE 2
`define LDS_C0_RESET 8'h08
`define LDS_C0_FIXMASK 8'h0B
`define LDS_C0_FIXVAL 8'h08

// Source select fields
`define LDS_SS_C2DIR 7
`define LDS_SS_T2DIR 6
`define LDS_SS_C1DIR 5
`define LDS_SS_T1DIR 4
`define LDS_SS_RESET 8'h00

// Write enable latch
`define LDS_WE_BIT 7
`define LDS_WE_SET 8'h80
`define LDS_WE_CLR 8'h00

// ADC filter and converter idle byte
`define LDS_FILT_COUNT 3'h4
`define LDS_DAC_IDLE 8'h00

`endif

/* File: verilog/lds_lut_mem.v */
module lds_lut_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    // Clock
    input wire clk,
    // Port A, host access
    input wire a_en,
    input wire a_we,
    input wire [AW-1:0] a_addr,
    input wire [DW-1:0] a_wdata,
    output reg [DW-1:0] a_rdata,
    // Port B, converter lookup
    input wire [AW-1:0] b_addr,
    output reg [DW-1:0] b_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read data come from registers
    always @(posedge clk) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule

/* File: verilog/lds_regs.v */
// Functional notes
// - Select bit 4 steers table one to row
// - Table one address is 90h plus row
// - Select bit 6 steers table two to row
// - Table two address is D0h plus row
// - Select bit 5 feeds converter one directly
// - Select bit 7 feeds converter two directly
// - Select bits default zero, ADC through tables
// - Volatility bit governs row and direct bytes
// - Writes need latch set, else no ack; latch codes to 86h always pass
// - Latch powers at zero, set/cleared by codes
// - Latch write leaves other bits unchanged
// - Status at 87h is read-only ADC output
// - ADC mode uses six upper result bits
// - Filter needs four agreeing conversions unless disabled
// - ADC result is straight binary byte
// - Reference bit zero internal, one external
// - Direction bit zero source, one sink
// - Addresses 88h-8Fh reserved; keep fixed bits
// - Control registers mapped at 80h to 86h
// - Converter bytes zero until first ADC result unless row or direct selected
`include "lds_defs.vh"

module lds_regs #(
    parameter ROW_W = 6,
    parameter DAC_W = 8,
    parameter FILT_N = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register access from the serial front end
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    output reg reg_nack,
    // Nonvolatile store request for volatility-governed bytes
    output reg nv_store,
    // ADC conversion input
    input wire adc_valid,
    input wire [7:0] adc_sample,
    // Converter and analogue controls
    output reg [DAC_W-1:0] conv1_byte,
    output reg [DAC_W-1:0] conv2_byte,
    output reg out1_direction_sel,
    output reg out2_direction_sel,
    output reg reference_mode_sel
);
    reg [7:0] ctrl0_q;
    reg [ROW_W-1:0] tbl1_row_bits_q;
    reg [ROW_W-1:0] tbl2_row_bits_q;
    reg [7:0] conv1_direct_bits_q;
    reg [7:0] conv2_direct_bits_q;
    reg [3:0] src_sel_q;
    reg write_enable_latch_q;
    reg [7:0] adc_result_bits_q;
    reg adc_valid_q;
    reg [5:0] filt_last_q;
    reg [2:0] filt_cnt_q;
    reg lut_phase_q;
    reg lut_rd_pend_q;

    wire tbl1_direct_sel = src_sel_q[0];
    wire tbl2_direct_sel = src_sel_q[2];
    wire conv1_direct_sel = src_sel_q[1];
    wire conv2_direct_sel = src_sel_q[3];
    wire ctrl_volatility_sel = ctrl0_q[`LDS_C0_VOLSEL];
    wire adc_filter_disable = ctrl0_q[`LDS_C0_FILTDIS];

    function in_table;
        input [7:0] a;
        begin
            in_table = (a >= `LDS_T1_BASE);
        end
    endfunction

    // Row selection per table
    wire [ROW_W-1:0] adc_row = adc_result_bits_q[7:8-ROW_W];
    wire [ROW_W-1:0] t1_row = tbl1_direct_sel ? tbl1_row_bits_q : adc_row;
    wire [ROW_W-1:0] t2_row = tbl2_direct_sel ? tbl2_row_bits_q : adc_row;
    wire [7:0] t1_addr = `LDS_T1_BASE + {2'b00, t1_row};
    wire [7:0] t2_addr = `LDS_T2_BASE + {2'b00, t2_row};

    // Alternate the lookup port between the two tables
    wire [7:0] b_addr = lut_phase_q ? t2_addr : t1_addr;
    wire [7:0] b_rdata;
    wire [7:0] a_rdata;
    wire is_tbl = in_table(reg_addr);
    wire tbl_wr = reg_wr && is_tbl && write_enable_latch_q;

    lds_lut_mem #(
        .AW(7),
        .DW(8)
    ) u_mem (
        .clk(clk),
        .a_en(tbl_wr),
        .a_we(tbl_wr),
        .a_addr(reg_addr[6:0]),
        .a_wdata(reg_wdata),
        .a_rdata(a_rdata),
        .b_addr(b_addr[6:0]),
        .b_rdata(b_rdata)
    );

    // Write acceptance
    wire we_code = (reg_addr == `LDS_ADDR_WECTL) &&
                   ((reg_wdata == `LDS_WE_SET) || (reg_wdata == `LDS_WE_CLR));
    wire wr_ok = reg_wr && (write_enable_latch_q || we_code);
    wire rsv = (reg_addr >= `LDS_ADDR_RSV_LO) && (reg_addr <= `LDS_ADDR_RSV_HI);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q <= `LDS_C0_RESET;
            tbl1_row_bits_q <= {ROW_W{1'b0}};
            tbl2_row_bits_q <= {ROW_W{1'b0}};
            conv1_direct_bits_q <= 8'h00;
            conv2_direct_bits_q <= 8'h00;
            src_sel_q <= 4'h0;
            write_enable_latch_q <= 1'b0;
            reg_ack <= 1'b0;
            reg_nack <= 1'b0;
            nv_store <= 1'b0;
        end else begin
            reg_ack <= (reg_wr && wr_ok) || reg_rd;
            reg_nack <= reg_wr && !wr_ok;
            nv_store <= 1'b0;
            if (wr_ok && !rsv) begin
                case (reg_addr)
                    `LDS_ADDR_CTRL0: begin
                        ctrl0_q <= (reg_wdata & ~`LDS_C0_FIXMASK) | `LDS_C0_FIXVAL;
                    end
                    `LDS_ADDR_T1ROW: begin
                        tbl1_row_bits_q <= reg_wdata[ROW_W-1:0];
                        nv_store <= ctrl_volatility_sel;
                    end
                    `LDS_ADDR_T2ROW: begin
                        tbl2_row_bits_q <= reg_wdata[ROW_W-1:0];
                        nv_store <= ctrl_volatility_sel;
                    end
                    `LDS_ADDR_C1DIR: begin
                        conv1_direct_bits_q <= reg_wdata;
                        nv_store <= ctrl_volatility_sel;
                    end
                    `LDS_ADDR_C2DIR: begin
                        conv2_direct_bits_q <= reg_wdata;
                        nv_store <= ctrl_volatility_sel;
                    end
                    `LDS_ADDR_SRCSEL: begin
                        src_sel_q <= reg_wdata[7:4];
                    end
                    `LDS_ADDR_WECTL: begin
                        if (we_code) begin
                            write_enable_latch_q <= reg_wdata[`LDS_WE_BIT];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux, one cycle after the request; only a read moves it
    reg rd_pend_q;
    reg rd_tbl_q;
    reg [7:0] rd_reg_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            rd_tbl_q <= 1'b0;
            rd_reg_q <= 8'h00;
        end else begin
            rd_pend_q <= reg_rd;
            rd_tbl_q <= reg_rd && is_tbl;
            if (reg_rd) begin
                case (reg_addr)
                    `LDS_ADDR_CTRL0: rd_reg_q <= ctrl0_q;
                    `LDS_ADDR_T1ROW: rd_reg_q <= {2'b00, tbl1_row_bits_q};
                    `LDS_ADDR_T2ROW: rd_reg_q <= {2'b00, tbl2_row_bits_q};
                    `LDS_ADDR_C1DIR: rd_reg_q <= conv1_direct_bits_q;
                    `LDS_ADDR_C2DIR: rd_reg_q <= conv2_direct_bits_q;
                    `LDS_ADDR_SRCSEL: rd_reg_q <= {src_sel_q, 4'h0};
                    `LDS_ADDR_WECTL: rd_reg_q <= {write_enable_latch_q, 7'h00};
                    `LDS_ADDR_ADCST: rd_reg_q <= adc_result_bits_q;
                    default: rd_reg_q <= 8'h00;
                endcase
            end
        end
    end

    // Read data stand until the next read completes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (rd_pend_q) begin
            reg_rdata <= rd_tbl_q ? a_rdata : rd_reg_q;
        end
    end

    // ADC output filter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_result_bits_q <= 8'h00;
            adc_valid_q <= 1'b0;
            filt_last_q <= 6'h00;
            filt_cnt_q <= 3'h0;
        end else if (adc_valid) begin
            filt_last_q <= adc_sample[7:2];
            if (adc_filter_disable) begin
                adc_result_bits_q <= adc_sample;
                adc_valid_q <= 1'b1;
                filt_cnt_q <= 3'h1;
            end else if (filt_cnt_q != 3'h0 && adc_sample[7:2] == filt_last_q) begin
                if (filt_cnt_q + 3'h1 >= `LDS_FILT_COUNT) begin
                    adc_result_bits_q <= adc_sample;
                    adc_valid_q <= 1'b1;
                    filt_cnt_q <= 3'h0;
                end else begin
                    filt_cnt_q <= filt_cnt_q + 3'h1;
                end
            end else begin
                filt_cnt_q <= 3'h1;
            end
        end
    end

    // Converter byte selection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lut_phase_q <= 1'b0;
            lut_rd_pend_q <= 1'b0;
            conv1_byte <= `LDS_DAC_IDLE;
            conv2_byte <= `LDS_DAC_IDLE;
            out1_direction_sel <= 1'b0;
            out2_direction_sel <= 1'b0;
            reference_mode_sel <= 1'b0;
        end else begin
            lut_phase_q <= ~lut_phase_q;
            lut_rd_pend_q <= lut_phase_q;
            out1_direction_sel <= ctrl0_q[`LDS_C0_OUT1DIR];
            out2_direction_sel <= ctrl0_q[`LDS_C0_OUT2DIR];
            reference_mode_sel <= ctrl0_q[`LDS_C0_REFMODE];
            if (conv1_direct_sel) begin
                conv1_byte <= conv1_direct_bits_q;
            end else if (!adc_valid_q && !tbl1_direct_sel) begin
                conv1_byte <= `LDS_DAC_IDLE;
            end else if (!lut_rd_pend_q) begin
                conv1_byte <= b_rdata;
            end
            if (conv2_direct_sel) begin
                conv2_byte <= conv2_direct_bits_q;
            end else if (!adc_valid_q && !tbl2_direct_sel) begin
                conv2_byte <= `LDS_DAC_IDLE;
            end else if (lut_rd_pend_q) begin
                conv2_byte <= b_rdata;
            end
        end
    end
endmodule

/* File: testbench/lds_regs_properties.sv */
module lds_regs_properties #(parameter DAC_W = 8) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register access
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_ack,
    input wire reg_nack,
    // Converter path
    input wire adc_valid,
    input wire [DAC_W-1:0] conv1_byte,
    input wire [DAC_W-1:0] conv2_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic we_q;
    logic seen_q;
    wire we_code = reg_addr == 8'h86 && (reg_wdata == 8'h80 || reg_wdata == 8'h00);
    // Shadow of the write enable latch and of first activity
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            if (reg_wr && we_code) we_q <= reg_wdata[7];
            if (adc_valid || reg_wr) seen_q <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence locked_wr_s;
        reg_wr && !we_q && !we_code;
    endsequence
    sequence open_wr_s;
        reg_wr && (we_q || we_code);
    endsequence
    read_ack_a: assert property (reg_rd |=> reg_ack && !reg_nack)
        else $error("read not acknowledged");
    locked_nack_a: assert property (locked_wr_s |=> reg_nack && !reg_ack)
        else $error("locked write not refused");
    open_ack_a: assert property (open_wr_s |=> reg_ack && !reg_nack)
        else $error("enabled write not acknowledged");
    idle_quiet_a: assert property (!reg_wr && !reg_rd |=> !reg_ack && !reg_nack)
        else $error("answer without request");
    reserved_zero_a: assert property (reg_rd && reg_addr[7:3] == 5'h11 |-> ##2 reg_rdata == 8'h00)
        else $error("reserved read not zero");
    rdata_hold_a: assert property (!$past(reg_rd, 2) |-> $stable(reg_rdata))
        else $error("read data changed without read");
    conv_idle_a: assert property (!seen_q |-> conv1_byte == 0 && conv2_byte == 0)
        else $error("converter byte not idle");
    latch_read_a: assert property (reg_rd && reg_addr == 8'h86 |=> ##1 reg_rdata == {$past(we_q, 2), 7'h00})
        else $error("latch register read wrong");
endmodule

bind lds_regs lds_regs_properties #(.DAC_W(DAC_W)) i_chk (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_nack(reg_nack), .adc_valid(adc_valid), .conv1_byte(conv1_byte), .conv2_byte(conv2_byte));

/* File: testbench/lds_host.sv */
module lds_host (
    // Clock
    input wire clk,
    // Register requests
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One request held over its sampling edge, then lines scrambled
    task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_rd = rd;
        reg_wr = !rd;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        repeat (2) @(posedge clk);
    endtask
endmodule

/* File: testbench/lut_dac_source_select_regs_bench.sv */
module lut_dac_source_select_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, adc_valid;
    logic [7:0] adc_sample, v1, v2, s, t;
    logic [5:0] r;
    logic [10:0] notes[$];
    wire reg_wr, reg_rd, reg_ack, reg_nack, nv_store, out1_direction_sel, out2_direction_sel, reference_mode_sel;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, conv1_byte, conv2_byte;
    int num_errors = 0;
    int n_checks = 0;
    lds_regs i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_nack(reg_nack),
        .nv_store(nv_store), .adc_valid(adc_valid), .adc_sample(adc_sample), .conv1_byte(conv1_byte),
        .conv2_byte(conv2_byte), .out1_direction_sel(out1_direction_sel),
        .out2_direction_sel(out2_direction_sel), .reference_mode_sel(reference_mode_sel));
    lds_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic nk);
        notes.push_back({1'b0, nk, 9'h000});
        i_host.acc(1'b0, a, d);
    endtask
    // Accepted write that must raise the store request
    task automatic wrv(input logic [7:0] a, input logic [7:0] d);
        notes.push_back({2'b10, 9'h000});
        i_host.acc(1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        notes.push_back({3'b001, d});
        i_host.acc(1'b1, a, 8'h00);
    endtask
    task automatic sample(input logic [7:0] v);
        @(posedge clk);
        #1 adc_valid = 1'b1;
        adc_sample = v;
        @(posedge clk);
        #1 adc_valid = 1'b0;
        adc_sample = ~v;
    endtask
    task automatic cv(input logic [7:0] e1, input logic [7:0] e2);
        repeat (6) @(posedge clk);
        #1 chk("conv1_byte", e1, conv1_byte);
        chk("conv2_byte", e2, conv2_byte);
    endtask
    // Answer monitor: oldest note against each acknowledge or refusal
    always @(posedge clk) begin
        logic [10:0] n;
        #2;
        if (reg_ack === 1'b1 || reg_nack === 1'b1) begin
            n = 11'h000;
            if (notes.size() == 0) begin
                num_errors++;
                $display("CHECK FAILED answer expected none seen one");
            end else begin
                n = notes.pop_front();
            end
            chk("reg_nack", {7'h00, n[9]}, {7'h00, reg_nack});
            chk("nv_store", {7'h00, n[10]}, {7'h00, nv_store});
            if (n[8]) begin
                @(posedge clk);
                #2 chk("reg_rdata", n[7:0], reg_rdata);
            end
        end
    end
    initial begin
        #20us;
        num_errors++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        adc_valid = 1'b0;
        adc_sample = 8'h00;
        s = 8'($urandom(31627));
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        cv(8'h00, 8'h00);
        chk("out2_direction_sel", 8'h00, {7'h00, out2_direction_sel});
        chk("out1_direction_sel", 8'h00, {7'h00, out1_direction_sel});
        chk("reference_mode_sel", 8'h00, {7'h00, reference_mode_sel});
        wr(8'h85, 8'h50, 1'b1);
        rd(8'h85, 8'h00);
        wr(8'h86, 8'h80, 1'b0);
        rd(8'h86, 8'h80);
        // Rows kept where both tables are within host reach
        r = 6'(16 + $urandom_range(31));
        v1 = 8'($urandom);
        v2 = 8'($urandom);
        s = {~r, s[1:0]};
        wr(8'h90 + {2'b00, r}, v1, 1'b0);
        wr(8'hD0 + {2'b00, r}, v2, 1'b0);
        wr(8'h90 + {2'b00, ~r}, ~v1, 1'b0);
        wr(8'hD0 + {2'b00, ~r}, ~v2, 1'b0);
        wr(8'h81, {2'b11, r}, 1'b0);
        rd(8'h81, {2'b00, r});
        wr(8'h82, {2'b10, r}, 1'b0);
        wr(8'h85, 8'h50, 1'b0);
        cv(v1, v2);
        wr(8'h83, v2, 1'b0);
        wr(8'h84, v1, 1'b0);
        wr(8'h85, 8'hF0, 1'b0);
        cv(v2, v1);
        wr(8'h85, 8'h00, 1'b0);
        wr(8'h80, 8'h18, 1'b0);
        sample(s);
        rd(8'h87, s);
        cv(~v1, ~v2);
        wr(8'h80, 8'h08, 1'b0);
        t = s ^ 8'hFC;
        repeat (3) sample(t);
        rd(8'h87, s);
        sample(t);
        rd(8'h87, t);
        wr(8'h80, 8'hEC, 1'b0);
        cv(v1, v2);
        chk("out2_direction_sel", 8'h01, {7'h00, out2_direction_sel});
        chk("reference_mode_sel", 8'h01, {7'h00, reference_mode_sel});
        chk("out1_direction_sel", 8'h01, {7'h00, out1_direction_sel});
        wrv(8'h83, v2);
        rd(8'h88 + 8'($urandom_range(7)), 8'h00);
        wr(8'h86, 8'h00, 1'b0);
        wr(8'h85, 8'hF0, 1'b1);
        rd(8'h85, 8'h00);
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule
